/* File: core/cbram_core.sv */
`timescale 1ns/10ps
`include "cbram_regs.svh"
module cbram_core (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Configuration.
	input wire cbram_pkg::cbram_mode_e mode,
	input wire cbram_pkg::cbram_width_e width_a,
	input wire cbram_pkg::cbram_width_e width_b,
	input wire logic out_reg_en,
	input wire logic parity_en,
	// Shadow store.
	input wire logic load_req,
	input wire logic save_req,
	input wire logic prog_we,
	input wire logic [`CBRAM_BYTE_AW-1:0] prog_addr,
	input wire logic [`CBRAM_LANE_W-1:0] prog_data,
	// Port A.
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [`CBRAM_LANES-1:0] a_be,
	input wire logic [`CBRAM_ADDR_W-1:0] a_addr,
	input wire logic [`CBRAM_DATA_W-1:0] a_wdata,
	output logic [`CBRAM_DATA_W-1:0] a_rdata,
	output logic a_rvalid,
	// Port B.
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [`CBRAM_LANES-1:0] b_be,
	input wire logic [`CBRAM_ADDR_W-1:0] b_addr,
	input wire logic [`CBRAM_DATA_W-1:0] b_wdata,
	output logic [`CBRAM_DATA_W-1:0] b_rdata,
	output logic b_rvalid,
	// Status.
	output logic busy,
	output logic cfg_err
);
	logic [`CBRAM_LANE_W-1:0] mem [0:`CBRAM_BYTES_N];
	logic [`CBRAM_LANE_W-1:0] shadow [0:`CBRAM_BYTES_N];
	cbram_pkg::cbram_state_e state_ff, nxt_state;
	logic [`CBRAM_BYTE_AW-1:0] cnt_ff, nxt_cnt;
	logic busy_ff, nxt_busy, cfg_err_ff, nxt_cfg_err, cfg_bad;
	logic [1:0][`CBRAM_ADDR_W-1:0] addr_ff, nxt_addr;
	logic [1:0][`CBRAM_DATA_W-1:0] wdata_ff, nxt_wdata, rword;
	logic [1:0][`CBRAM_DATA_W-1:0] pipe_ff, nxt_pipe, rdata_ff, nxt_rdata;
	logic [1:0][`CBRAM_LANES-1:0] be_ff, nxt_be;
	logic [1:0] wr_ff, nxt_wr, rd_ff, nxt_rd, pv_ff, nxt_pv, rv_ff, nxt_rv;
	logic [1:0][`CBRAM_BYTE_AW-1:0] byte_idx;
	logic [1:0][2:0] bit_off, lanes;
	logic [1:0][7:0] bit_mask;
	logic [1:0] narrow;

	// ======================================================================
	// Word to array mapping, one mapper per port so shapes stay independent.
	cbram_port_map u_map_a (
		.width(width_a),
		.addr(addr_ff[0]),
		.byte_idx(byte_idx[0]),
		.bit_off(bit_off[0]),
		.bit_mask(bit_mask[0]),
		.lanes(lanes[0]),
		.narrow(narrow[0])
	);
	cbram_port_map u_map_b (
		.width(width_b),
		.addr(addr_ff[1]),
		.byte_idx(byte_idx[1]),
		.bit_off(bit_off[1]),
		.bit_mask(bit_mask[1]),
		.lanes(lanes[1]),
		.narrow(narrow[1])
	);

	// ======================================================================
	// Shadow copy sequencer; a reset is a power-up and starts a load.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		unique case (state_ff)
			cbram_pkg::IDLE: begin
				if (load_req) begin
					nxt_state = cbram_pkg::LOAD;
					nxt_cnt = `CBRAM_CNT_RST;
				end else if (save_req) begin
					nxt_state = cbram_pkg::SAVE;
					nxt_cnt = `CBRAM_CNT_RST;
				end
			end
			cbram_pkg::LOAD, cbram_pkg::SAVE: begin
				nxt_cnt = cnt_ff + 11'h001;
				if (cnt_ff == `CBRAM_LAST_BYTE) begin
					nxt_state = cbram_pkg::IDLE;
				end
			end
		endcase
		nxt_busy = (nxt_state != cbram_pkg::IDLE);
		// The 36-bit shape has no room for two full ports.
		cfg_bad = (mode == cbram_pkg::TRUE_DUAL) &&
			((width_a == cbram_pkg::W36) || (width_b == cbram_pkg::W36));
		nxt_cfg_err = cfg_bad;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_ff <= cbram_pkg::LOAD;
			cnt_ff <= `CBRAM_CNT_RST;
			busy_ff <= 1'b1;
			cfg_err_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			cfg_err_ff <= nxt_cfg_err;
		end
	end

	// ======================================================================
	// Input capture. Requests made while busy or misconfigured are dropped.
	always_comb begin
		nxt_addr[0] = a_addr;
		nxt_addr[1] = b_addr;
		nxt_wdata[0] = a_wdata;
		nxt_wdata[1] = b_wdata;
		nxt_be[0] = a_be;
		nxt_be[1] = b_be;
		nxt_wr[0] = a_en && a_we && !busy_ff && !cfg_bad;
		nxt_rd[0] = a_en && !a_we && !busy_ff && !cfg_bad;
		// Port B is unused in single port mode and read only in pseudo dual.
		nxt_wr[1] = b_en && b_we && !busy_ff && !cfg_bad && (mode == cbram_pkg::TRUE_DUAL);
		nxt_rd[1] = b_en && !b_we && !busy_ff && !cfg_bad && (mode != cbram_pkg::SINGLE);
	end

	always_ff @(posedge clk_sys) begin
		addr_ff <= nxt_addr;
		wdata_ff <= nxt_wdata;
		be_ff <= nxt_be;
		if (reset) begin
			wr_ff <= 2'b00;
			rd_ff <= 2'b00;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	// ======================================================================
	// Array read from the captured address; parity reads as zero when off.
	always_comb begin
		logic [`CBRAM_LANE_W-1:0] lb;
		lb = '0;
		rword = '0;
		for (int p = 0; p < 2; p++) begin
			if (narrow[p]) begin
				rword[p][7:0] = (mem[byte_idx[p]][7:0] & bit_mask[p]) >> bit_off[p];
			end else begin
				for (int l = 0; l < `CBRAM_LANES; l++) begin
					if (3'(l) < lanes[p]) begin
						lb = mem[byte_idx[p] + 11'(l)];
						lb[`CBRAM_PAR_BIT] = lb[`CBRAM_PAR_BIT] & parity_en;
						rword[p][l*`CBRAM_LANE_W +: `CBRAM_LANE_W] = lb;
					end
				end
			end
		end
	end

	// ======================================================================
	// Array writes. Port A is applied last so it wins a byte both ports hit.
	// Reads see the old contents of a byte written in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (state_ff == cbram_pkg::LOAD) begin
			mem[cnt_ff] <= shadow[cnt_ff];
		end else if (state_ff == cbram_pkg::IDLE) begin
			for (int p = 1; p >= 0; p--) begin
				if (wr_ff[p] && narrow[p]) begin
					mem[byte_idx[p]][7:0] <= (mem[byte_idx[p]][7:0] & ~bit_mask[p]) |
						((wdata_ff[p][7:0] << bit_off[p]) & bit_mask[p]);
				end else if (wr_ff[p]) begin
					for (int l = 0; l < `CBRAM_LANES; l++) begin
						if ((3'(l) < lanes[p]) && ((lanes[p] == 3'h1) || be_ff[p][l])) begin
							mem[byte_idx[p] + 11'(l)] <= {parity_en &
								wdata_ff[p][l*`CBRAM_LANE_W + `CBRAM_PAR_BIT],
								wdata_ff[p][l*`CBRAM_LANE_W +: 8]};
						end
					end
				end
			end
		end
	end

	// Shadow store: copy back, or programming whenever no save runs.
	always_ff @(posedge clk_sys) begin
		if (state_ff == cbram_pkg::SAVE) begin
			shadow[cnt_ff] <= mem[cnt_ff];
		end else if (prog_we) begin
			shadow[prog_addr] <= prog_data;
		end
	end

	// ======================================================================
	// Read output path; the optional stage trades a cycle for timing slack.
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			nxt_pipe[p] = rd_ff[p] ? rword[p] : pipe_ff[p];
			nxt_pv[p] = rd_ff[p];
			if (out_reg_en) begin
				nxt_rv[p] = pv_ff[p];
				nxt_rdata[p] = pv_ff[p] ? pipe_ff[p] : rdata_ff[p];
			end else begin
				nxt_rv[p] = rd_ff[p];
				nxt_rdata[p] = rd_ff[p] ? rword[p] : rdata_ff[p];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pipe_ff <= '0;
			pv_ff <= 2'b00;
			rdata_ff <= '0;
			rv_ff <= 2'b00;
		end else begin
			pipe_ff <= nxt_pipe;
			pv_ff <= nxt_pv;
			rdata_ff <= nxt_rdata;
			rv_ff <= nxt_rv;
		end
	end

	// Outputs come straight from flip-flops.
	assign a_rdata = rdata_ff[0];
	assign a_rvalid = rv_ff[0];
	assign b_rdata = rdata_ff[1];
	assign b_rvalid = rv_ff[1];
	assign busy = busy_ff;
	assign cfg_err = cfg_err_ff;

	// ======================================================================
	// Assertions.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	property p_cap_addr;
		(a_en && !busy_ff && !cfg_bad) |=> (addr_ff[0] == $past(a_addr)) && (rd_ff[0] == !$past(a_we));
	endproperty
	a_cap_addr: assert property (p_cap_addr) else $error("Port A request not captured.");

	property p_lat_direct;
		(rd_ff[0] && !out_reg_en) |=> rv_ff[0] && (rdata_ff[0] == $past(rword[0]));
	endproperty
	a_lat_direct: assert property (p_lat_direct) else $error("Direct read data late or wrong.");

	property p_lat_reg;
		(rd_ff[0] && out_reg_en) ##1 out_reg_en |=> rv_ff[0] && (rdata_ff[0] == $past(rword[0], 2));
	endproperty
	a_lat_reg: assert property (p_lat_reg) else $error("Registered read data late or wrong.");

	property p_no36_tdp;
		(mode == cbram_pkg::TRUE_DUAL && width_a == cbram_pkg::W36) |=> cfg_err_ff && !rd_ff[0] && !wr_ff[0];
	endproperty
	a_no36_tdp: assert property (p_no36_tdp) else $error("36-bit shape accepted in true dual port.");

	property p_port_b_mode;
		(mode != cbram_pkg::TRUE_DUAL) |=> !wr_ff[1] && !(($past(mode) == cbram_pkg::SINGLE) && rd_ff[1]);
	endproperty
	a_port_b_mode: assert property (p_port_b_mode) else $error("Port B access outside its mode.");

	property p_load_copy;
		(state_ff == cbram_pkg::LOAD) |=> mem[$past(cnt_ff)] === $past(shadow[cnt_ff]);
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("Shadow byte not loaded.");

	property p_save_copy;
		(state_ff == cbram_pkg::SAVE) |=> shadow[$past(cnt_ff)] === $past(mem[cnt_ff]);
	endproperty
	a_save_copy: assert property (p_save_copy) else $error("Array byte not saved.");

	property p_parity_off;
		(!parity_en && rd_ff[0] && !narrow[0]) |-> rword[0][`CBRAM_PAR_BIT] == 1'b0;
	endproperty
	a_parity_off: assert property (p_parity_off) else $error("Parity bit read while disabled.");

	property p_be_hold;
		(state_ff == cbram_pkg::IDLE && wr_ff[0] && !wr_ff[1] && lanes[0] == 3'h2 && !be_ff[0][0])
			|=> mem[$past(byte_idx[0])] == $past(mem[byte_idx[0]]);
	endproperty
	a_be_hold: assert property (p_be_hold) else $error("Disabled byte lane was written.");

	property p_bit_order;
		(width_a == cbram_pkg::W1 && rd_ff[0]) |-> rword[0][0] == mem[addr_ff[0][13:3]][addr_ff[0][2:0]];
	endproperty
	a_bit_order: assert property (p_bit_order) else $error("Bit mapping out of order.");

	c_mixed: cover property (mode == cbram_pkg::TRUE_DUAL && width_a != width_b && rd_ff == 2'b11);
	c_wide36: cover property (width_a == cbram_pkg::W36 && wr_ff[0] && be_ff[0] != 4'hF);
	c_load_done: cover property (state_ff == cbram_pkg::LOAD ##1 state_ff == cbram_pkg::IDLE);
	c_save: cover property (state_ff == cbram_pkg::IDLE && save_req && !load_req);
endmodule // cbram_core

/* File: core/cbram_regs.svh */
`ifndef CBRAM_REGS_SVH
`define CBRAM_REGS_SVH
// ==========================================================================

// ==========================================================================
// Geometry
`define CBRAM_BITS 18432
`define CBRAM_ADDR_W 14
`define CBRAM_DATA_W 36
`define CBRAM_BYTE_AW 11
`define CBRAM_LANE_W 9
`define CBRAM_LANES 4
`define CBRAM_PAR_BIT 8
`define CBRAM_LAST_BYTE 11'h7FF
`define CBRAM_BYTES_N 2047
`define CBRAM_CNT_RST 11'h000
`endif

/* File: core/cbram_pkg.sv */
// ==========================================================================
// Types shared by the block RAM core and its port mapper.
package cbram_pkg;
	typedef enum logic [1:0] {SINGLE, TRUE_DUAL, PSEUDO_DUAL} cbram_mode_e;
	typedef enum logic [2:0] {W1, W2, W4, W9, W18, W36} cbram_width_e;
	typedef enum logic [1:0] {IDLE, LOAD, SAVE} cbram_state_e;
endpackage

/* File: core/cbram_port_map.sv */
`timescale 1ns/10ps
`include "cbram_regs.svh"
module cbram_port_map (
	// Port shape and captured word address.
	input wire cbram_pkg::cbram_width_e width,
	input wire logic [`CBRAM_ADDR_W-1:0] addr,
	// Location of the word in the byte array.
	output logic [`CBRAM_BYTE_AW-1:0] byte_idx,
	output logic [2:0] bit_off,
	output logic [7:0] bit_mask,
	output logic [2:0] lanes,
	output logic narrow
);
	logic [`CBRAM_ADDR_W-1:0] bit_pos;
	logic [7:0] base_mask;

	// ======================================================================
	// Narrow shapes index a flat bit stream, wide shapes whole 9-bit lanes.
	always_comb begin
		bit_pos = '0;
		base_mask = 8'h00;
		lanes = 3'h0;
		narrow = 1'b1;
		byte_idx = '0;
		unique case (width)
			cbram_pkg::W1: begin
				bit_pos = addr;
				base_mask = 8'h01;
			end
			cbram_pkg::W2: begin
				bit_pos = {addr[12:0], 1'b0};
				base_mask = 8'h03;
			end
			cbram_pkg::W4: begin
				bit_pos = {addr[11:0], 2'b00};
				base_mask = 8'h0F;
			end
			cbram_pkg::W9: begin
				narrow = 1'b0;
				lanes = 3'h1;
				byte_idx = addr[10:0];
			end
			cbram_pkg::W18: begin
				narrow = 1'b0;
				lanes = 3'h2;
				byte_idx = {addr[9:0], 1'b0};
			end
			cbram_pkg::W36: begin
				narrow = 1'b0;
				lanes = 3'h4;
				byte_idx = {addr[8:0], 2'b00};
			end
			default: begin
				// An illegal shape code touches nothing.
				base_mask = 8'h00;
			end
		endcase
		if (narrow) begin
			byte_idx = bit_pos[13:3];
		end
		bit_off = bit_pos[2:0];
		bit_mask = base_mask << bit_off;
	end
endmodule // cbram_port_map

/* File: dv/cbram_fabric.sv */
`timescale 1ns/10ps
// ==========
// Fabric logic that drives one memory port.
module cbram_fabric (
	// Clock.
	input wire logic clk_sys,
	// Request.
	output logic en,
	output logic we,
	output logic [3:0] be,
	output logic [13:0] addr,
	output logic [35:0] wdata,
	// Answer.
	input wire logic [35:0] rdata,
	input wire logic rvalid
);
	// The port starts idle.
	initial begin
		en = 1'h0;
		we = 1'h0;
		be = 4'h0;
		addr = 14'h0000;
		wdata = 36'h0;
	end

	// One request for one edge. Released lines show the inverse so a stale value never passes.
	task automatic xfer(input logic w, input logic [3:0] b, input logic [13:0] a, input logic [35:0] d,
		output logic [35:0] q, output int lat);
		@(posedge clk_sys);
		en <= 1'h1;
		we <= w;
		be <= b;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		en <= 1'h0;
		we <= ~w;
		be <= ~b;
		addr <= ~a;
		wdata <= ~d;
		lat = 0;
		q = 36'h0;
		// The whole window is watched, so a late or doubled answer is seen too.
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk_sys);
			#1;
			if (rvalid === 1'h1 && lat == 0) begin
				lat = i;
				q = rdata;
			end else if (rvalid === 1'h1) begin
				// A second pulse for one request reads back as an impossible latency.
				lat = 9;
			end
		end
	endtask
endmodule // cbram_fabric

/* File: dv/tb.sv */
`timescale 1ns/10ps
// ==========
// Bench for the block RAM core against a lane-array model.
module tb;
	logic clk_sys, reset, out_reg_en, parity_en, load_req, save_req, prog_we;
	cbram_pkg::cbram_mode_e mode;
	cbram_pkg::cbram_width_e width_a, width_b;
	logic [10:0] prog_addr;
	logic [8:0] prog_data;
	wire logic a_en, a_we, b_en, b_we;
	wire logic [3:0] a_be, b_be;
	wire logic [13:0] a_addr, b_addr;
	wire logic [35:0] a_wdata, b_wdata;
	logic [35:0] a_rdata, b_rdata;
	logic a_rvalid, b_rvalid, busy, cfg_err;
	logic [8:0] mem [0:2047];
	logic [8:0] shadow [0:2047];
	logic [31:0] rng = 32'h0001119E;
	int errors = 0;
	int checked = 0;

	// ==========
	// Device and the fabric on both ports.
	cbram_core dut (.clk_sys(clk_sys), .reset(reset), .mode(mode), .width_a(width_a), .width_b(width_b),
		.out_reg_en(out_reg_en), .parity_en(parity_en), .load_req(load_req), .save_req(save_req),
		.prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data), .a_en(a_en), .a_we(a_we),
		.a_be(a_be), .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata), .a_rvalid(a_rvalid),
		.b_en(b_en), .b_we(b_we), .b_be(b_be), .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata),
		.b_rvalid(b_rvalid), .busy(busy), .cfg_err(cfg_err));
	cbram_fabric fab_a (.clk_sys(clk_sys), .en(a_en), .we(a_we), .be(a_be), .addr(a_addr),
		.wdata(a_wdata), .rdata(a_rdata), .rvalid(a_rvalid));
	cbram_fabric fab_b (.clk_sys(clk_sys), .en(b_en), .we(b_we), .be(b_be), .addr(b_addr),
		.wdata(b_wdata), .rdata(b_rdata), .rvalid(b_rvalid));

	// Free-running 125 MHz clock.
	initial begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ==========
	// Model and helpers.
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic int lanes(int w);
		return w == 3 ? 1 : (w == 4 ? 2 : 4);
	endfunction

	function automatic logic [35:0] mask(int w);
		return w < 3 ? 36'((64'h1 << (1 << w)) - 1) : 36'((64'h1 << (9 * lanes(w))) - 1);
	endfunction

	// Bit stream order is word by word, LSB first; narrow shapes skip the parity bit.
	function automatic logic [35:0] mdl(int w, int a, logic wr, logic [3:0] b, logic [35:0] d);
		logic [35:0] q;
		int n, x;
		q = 36'h0;
		n = (w < 3) ? (1 << w) : lanes(w);
		for (int k = 0; k < n; k++) begin
			x = a * n + k;
			if (w < 3) begin
				q[k] = mem[x / 8][x % 8];
				if (wr) mem[x / 8][x % 8] = d[k];
			end else begin
				q[9 * k +: 9] = mem[x] & {parity_en, 8'hFF};
				if (wr && (w == 3 || b[k])) mem[x] = d[9 * k +: 9] & {parity_en, 8'hFF};
			end
		end
		return q;
	endfunction

	task automatic chk_data(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_small(input logic [7:0] g, input logic [7:0] e);
		chk_data(36'(g), 36'(e));
	endtask

	// One access on port p; a refused one must leave the model and the outputs alone.
	task automatic acc(input int p, input logic w, input int a, input logic ok);
		logic [3:0] b;
		logic [35:0] q, e, d;
		int lat, wd;
		b = 4'(rnd());
		d = 36'({rnd(), rnd()});
		wd = (p == 0) ? width_a : width_b;
		a = a & ((1 << (14 - wd)) - 1);
		e = ok ? mdl(wd, a, w, b, d) : 36'h0;
		if (p == 0) fab_a.xfer(w, b, 14'(a), d, q, lat);
		else fab_b.xfer(w, b, 14'(a), d, q, lat);
		chk_small(8'(lat), (ok && !w) ? 8'(1 + out_reg_en) : 8'h00);
		if (ok && !w) chk_data(q & mask(wd), e & mask(wd));
	endtask

	task automatic cfg(input int m, input int wa, input int wb, input logic o);
		@(posedge clk_sys);
		mode <= cbram_pkg::cbram_mode_e'(m);
		width_a <= cbram_pkg::cbram_width_e'(wa);
		width_b <= cbram_pkg::cbram_width_e'(wb);
		out_reg_en <= o;
		parity_en <= 1'(rnd());
		repeat (3) @(posedge clk_sys);
		chk_small(8'(cfg_err), 8'(m == 1 && (wa == 5 || wb == 5)));
	endtask

	// Bounded wait for the shadow engine; a hang ends the run.
	task automatic idle();
		for (int i = 0; busy !== 1'h0; i++) begin
			if (i > 3000) begin
				errors++;
				print_verdict();
			end
			@(posedge clk_sys);
			#1;
		end
	endtask

	task automatic shadow_op(input logic ld);
		@(posedge clk_sys);
		load_req <= ld;
		save_req <= ~ld;
		@(posedge clk_sys);
		load_req <= 1'h0;
		save_req <= 1'h0;
		#1;
		chk_small(8'(busy), 8'h01);
		for (int i = 0; i < 2048; i++) begin
			if (ld) mem[i] = shadow[i];
			else shadow[i] = mem[i];
		end
		acc(0, 1'h0, 0, 1'h0);
		idle();
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ==========
	// Main sequence.
	initial begin
		logic [8:0] v;
		reset = 1'h1;
		mode = cbram_pkg::SINGLE;
		width_a = cbram_pkg::W9;
		width_b = cbram_pkg::W9;
		out_reg_en = 1'h0;
		parity_en = 1'h1;
		load_req = 1'h0;
		save_req = 1'h0;
		prog_we = 1'h0;
		prog_addr = 11'h000;
		prog_data = 9'h000;
		repeat (12) @(posedge clk_sys);
		reset <= 1'h0;
		@(posedge clk_sys);
		#1;
		chk_small(8'(busy), 8'h01);
		idle();
		for (int i = 0; i < 2048; i++) begin
			v = 9'(rnd());
			@(posedge clk_sys);
			prog_we <= 1'h1;
			prog_addr <= 11'(i);
			prog_data <= v;
			shadow[i] = v;
		end
		@(posedge clk_sys);
		prog_we <= 1'h0;
		shadow_op(1'h1);
		repeat (12) acc(0, 1'h0, int'(rnd()), 1'h1);
		$display("test shadow load done");
		for (int w = 0; w < 6; w++) begin
			for (int o = 0; o < 2; o++) begin
				cfg(cbram_pkg::SINGLE, w, w, 1'(o));
				repeat (3) begin
					v = 9'(rnd());
					acc(0, 1'h1, v, 1'h1);
					acc(0, 1'h0, v, 1'h1);
					acc(1, 1'h0, v, 1'h0);
				end
			end
		end
		$display("test widths done");
		for (int w = 0; w < 5; w++) begin
			cfg(cbram_pkg::TRUE_DUAL, w, 4 - w, 1'(w));
			repeat (10) acc(int'(rnd() % 2), 1'(rnd()), int'(rnd() % 8), 1'h1);
		end
		cfg(cbram_pkg::TRUE_DUAL, 5, 3, 1'h0);
		acc(0, 1'h0, 1, 1'h0);
		cfg(cbram_pkg::PSEUDO_DUAL, 3, 5, 1'h0);
		acc(0, 1'h1, 2, 1'h1);
		acc(1, 1'h1, 0, 1'h0);
		acc(1, 1'h0, 0, 1'h1);
		$display("test port modes done");
		cfg(cbram_pkg::SINGLE, 3, 3, 1'h0);
		shadow_op(1'h0);
		repeat (8) acc(0, 1'h1, int'(rnd() % 8), 1'h1);
		shadow_op(1'h1);
		for (int a = 0; a < 8; a++) acc(0, 1'h0, a, 1'h1);
		$display("test shadow save done");
		print_verdict();
	end
endmodule // tb
